// ==== pkg/rsc_pkg.sv ====
package rsc_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_GUARD   = 4'h0;
  localparam logic [3:0] ADDR_CAUSE   = 4'h1;
  localparam logic [3:0] ADDR_LVSEL   = 4'h2;
  localparam logic [3:0] ADDR_WDTKEY  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h5;

  // Reset values and alternate valid key patterns
  localparam logic [7:0] GUARD_POR   = 8'h55;
  localparam logic [7:0] GUARD_ALT   = 8'hAA;
  localparam logic [7:0] LVSEL_POR   = 8'h66;
  localparam logic [4:0] WDTKEY_POR  = 5'h0A;
  localparam logic [4:0] WDTKEY_OFF  = 5'h15;

  // Low-voltage select codes
  localparam logic [7:0] LV_1V7  = 8'h66;
  localparam logic [7:0] LV_1V9  = 8'h55;
  localparam logic [7:0] LV_2V55 = 8'h33;
  localparam logic [7:0] LV_3V15 = 8'h99;
  localparam logic [7:0] LV_3V8  = 8'hAA;
  localparam logic [7:0] LV_OFF  = 8'hF0;

  // Cause flag bit positions
  localparam int BIT_WDT   = 0;
  localparam int BIT_LVCFG = 1;
  localparam int BIT_LV    = 2;
  localparam int BIT_GUARD = 3;

  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int POR_DELAY_MS   = 50;
  localparam int POR_DELAY_CYC  = POR_DELAY_MS * 1000 * CLK_MHZ;
  localparam int LV_MIN_US      = 1000;
  localparam int LV_MIN_CYC     = LV_MIN_US * CLK_MHZ;
  localparam int TRIG_SLOW_CYC  = 2;

  // Threshold select one-hot
  typedef struct packed {
    logic lv_3v8;
    logic lv_3v15;
    logic lv_2v55;
    logic lv_1v9;
    logic lv_1v7;
  } rsc_thr_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } rsc_state_t;

endpackage : rsc_pkg

// ==== logic/rsc_top.sv ====
`timescale 1ns/1ps
module rsc_top #(
  parameter int POR_DELAY = rsc_pkg::POR_DELAY_CYC,
  parameter int LV_MIN    = rsc_pkg::LV_MIN_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        SLOW_OSC,
  input  wire logic        LV_BELOW_N,
  input  wire logic        POWER_DOWN,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  output logic      [4:0]  LV_THRESH,
  output logic             LV_ENABLE,
  output logic             SYS_RST_N,
  output logic      [15:0] PC_INIT,
  output logic      [7:0]  PORT_INIT,
  output logic             IRQ
);

  // Synchronisers: slow osc and supply comparator, three stages each
  logic [2:0] osc_sync;
  logic [2:0] lv_sync;
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      osc_sync <= 3'b000;
      lv_sync  <= 3'b111;
    end
    else
    begin
      osc_sync <= {osc_sync[1:0], SLOW_OSC};
      lv_sync  <= {lv_sync[1:0], LV_BELOW_N};
    end
  end

  // Filtered levels change only when stages two and three agree
  logic osc_lvl;
  logic lv_ok;
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      osc_lvl <= 1'b0;
      lv_ok   <= 1'b1;
    end
    else
    begin
      if (osc_sync[1] == osc_sync[2]) osc_lvl <= osc_sync[2];
      if (lv_sync[1] == lv_sync[2]) lv_ok <= lv_sync[2];
    end
  end

  logic osc_prev;
  wire  osc_rise = osc_lvl & ~osc_prev;

  // Register port decode
  wire wr_guard = WR && (ADDR == rsc_pkg::ADDR_GUARD);
  wire wr_cause = WR && (ADDR == rsc_pkg::ADDR_CAUSE);
  wire wr_lvsel = WR && (ADDR == rsc_pkg::ADDR_LVSEL);
  wire wr_wdt   = WR && (ADDR == rsc_pkg::ADDR_WDTKEY);
  wire wr_ist   = WR && (ADDR == rsc_pkg::ADDR_IRQ_ST);
  wire wr_imsk  = WR && (ADDR == rsc_pkg::ADDR_IRQ_MSK);

  logic [7:0] guard_key;
  logic [7:0] lvsel;
  logic [4:0] wdt_key;
  logic [3:0] cause;
  logic [3:0] irq_st;
  logic [3:0] irq_msk;

  // Key and select validity
  wire guard_ok = (guard_key == rsc_pkg::GUARD_POR) ||
                  (guard_key == rsc_pkg::GUARD_ALT);
  wire wdt_ok   = (wdt_key == rsc_pkg::WDTKEY_POR) || (wdt_key == rsc_pkg::WDTKEY_OFF);
  rsc_pkg::rsc_thr_t thr;
  assign thr.lv_1v7  = (lvsel == rsc_pkg::LV_1V7);
  assign thr.lv_1v9  = (lvsel == rsc_pkg::LV_1V9);
  assign thr.lv_2v55 = (lvsel == rsc_pkg::LV_2V55);
  assign thr.lv_3v15 = (lvsel == rsc_pkg::LV_3V15);
  assign thr.lv_3v8  = (lvsel == rsc_pkg::LV_3V8);
  wire lv_off   = (lvsel == rsc_pkg::LV_OFF);
  wire lvsel_ok = (|thr) || lv_off;
  wire lv_en    = (|thr) && !POWER_DOWN;

  // Slow-cycle counters: trigger on second slow edge, one to two slow cycles after the fault
  logic [1:0] g_cnt;
  logic [1:0] l_cnt;
  logic [1:0] w_cnt;
  wire g_fire = !guard_ok && osc_rise && (g_cnt == 2'(rsc_pkg::TRIG_SLOW_CYC - 1));
  wire l_fire = !lvsel_ok && osc_rise && (l_cnt == 2'(rsc_pkg::TRIG_SLOW_CYC - 1));
  wire w_fire = !wdt_ok && osc_rise && (w_cnt == 2'(rsc_pkg::TRIG_SLOW_CYC - 1));

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      osc_prev <= 1'b0;
      g_cnt    <= 2'b00;
      l_cnt    <= 2'b00;
      w_cnt    <= 2'b00;
    end
    else
    begin
      osc_prev <= osc_lvl;
      g_cnt <= guard_ok ? 2'b00 : (osc_rise && !g_fire) ? g_cnt + 2'b01 : g_cnt;
      l_cnt <= lvsel_ok ? 2'b00 : (osc_rise && !l_fire) ? l_cnt + 2'b01 : l_cnt;
      w_cnt <= wdt_ok ? 2'b00 : (osc_rise && !w_fire) ? w_cnt + 2'b01 : w_cnt;
    end
  end

  // Low-supply qualification; short dips never reach the limit
  logic [31:0] lv_cnt;
  wire lv_fire = lv_en && !lv_ok && (lv_cnt == 32'(LV_MIN - 1));
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      lv_cnt <= '0;
    else if (!lv_en || lv_ok)
      lv_cnt <= '0;
    else if (!lv_fire && lv_cnt != 32'(LV_MIN - 1))
      lv_cnt <= lv_cnt + 32'd1;
  end
  // Supply still low after qualification keeps reset asserted
  wire lv_hold = lv_en && !lv_ok && (lv_cnt == 32'(LV_MIN - 1));

  // Registers; flags are cleared only by software writes
  wire [3:0] set_ev = {g_fire, lv_fire, l_fire, w_fire};
  wire [3:0] clr_cause = wr_cause ? ~WDATA[3:0] : 4'h0;
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      guard_key <= rsc_pkg::GUARD_POR;
      lvsel     <= rsc_pkg::LVSEL_POR;
      wdt_key   <= rsc_pkg::WDTKEY_POR;
      cause     <= 4'h0;
      irq_st    <= 4'h0;
      irq_msk   <= 4'h0;
    end
    else
    begin
      if (g_fire) guard_key <= rsc_pkg::GUARD_POR;
      else if (wr_guard) guard_key <= WDATA;
      if (l_fire) lvsel <= rsc_pkg::LVSEL_POR;
      else if (wr_lvsel) lvsel <= WDATA;
      if (w_fire) wdt_key <= rsc_pkg::WDTKEY_POR;
      else if (wr_wdt) wdt_key <= WDATA[7:3];
      cause   <= (cause & ~clr_cause) | set_ev;
      irq_st  <= (irq_st & ~(wr_ist ? WDATA[3:0] : 4'h0)) | set_ev;
      if (wr_imsk) irq_msk <= WDATA[3:0];
    end
  end

  // Combined reset request and start-up sequencer
  wire trig_rst = g_fire | l_fire | w_fire;
  wire supply_rst = lv_hold;
  rsc_pkg::rsc_state_t state;
  rsc_pkg::rsc_state_t next_state;
  logic [31:0] dly_cnt;
  wire dly_done = (dly_cnt == 32'(POR_DELAY - 1));

  always_comb
  begin
    next_state = state;
    case (state)
      rsc_pkg::ST_HOLD: if (!supply_rst) next_state = rsc_pkg::ST_WAIT;
      rsc_pkg::ST_WAIT:
        if (supply_rst) next_state = rsc_pkg::ST_HOLD;
        else if (dly_done) next_state = rsc_pkg::ST_RUN;
      rsc_pkg::ST_RUN:
        if (supply_rst || trig_rst) next_state = rsc_pkg::ST_HOLD;
      default: next_state = rsc_pkg::ST_HOLD;
    endcase
  end

  // Release on a clock edge, so the core leaves reset synchronously
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state   <= rsc_pkg::ST_HOLD;
      dly_cnt <= '0;
    end
    else
    begin
      state   <= next_state;
      dly_cnt <= (state == rsc_pkg::ST_WAIT && !dly_done) ? dly_cnt + 32'd1 : '0;
    end
  end

  // Read port, one cycle latency
  logic [7:0] rd_mux;
  assign rd_mux = (ADDR == rsc_pkg::ADDR_GUARD)   ? guard_key :
                  (ADDR == rsc_pkg::ADDR_CAUSE)   ? {4'h0, cause} :
                  (ADDR == rsc_pkg::ADDR_LVSEL)   ? lvsel :
                  (ADDR == rsc_pkg::ADDR_WDTKEY)  ? {wdt_key, 3'b000} :
                  (ADDR == rsc_pkg::ADDR_IRQ_ST)  ? {4'h0, irq_st} :
                  (ADDR == rsc_pkg::ADDR_IRQ_MSK) ? {4'h0, irq_msk} : 8'h00;

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RDATA     <= 8'h00;
      SYS_RST_N <= 1'b0;
      LV_THRESH <= 5'h00;
      LV_ENABLE <= 1'b0;
    end
    else
    begin
      RDATA     <= RD ? rd_mux : 8'h00;
      SYS_RST_N <= (state == rsc_pkg::ST_RUN) && (next_state == rsc_pkg::ST_RUN);
      LV_THRESH <= thr;
      LV_ENABLE <= lv_en;
    end
  end

  // Core start values held constant while in reset
  assign PC_INIT   = 16'h0000;
  assign PORT_INIT = 8'hFF;
  assign IRQ       = |(irq_st & irq_msk);

  // Assertions
  // Guard key violation sets its flag and pulls the reset
  guard_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    g_fire |=> cause[rsc_pkg::BIT_GUARD] && !SYS_RST_N)
    else $error("guard flag not set");

  // Low-supply flag only drops on a software write of zero
  flag_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $fell(cause[rsc_pkg::BIT_LV]) |-> $past(wr_cause) && !$past(WDATA[2]))
    else $error("lv flag cleared without write");

  // Bad select code restores the power-on code
  sel_restore_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    l_fire |=> lvsel == rsc_pkg::LVSEL_POR && cause[rsc_pkg::BIT_LVCFG])
    else $error("select not restored");

  // Genuine low supply leaves the select code alone
  sel_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (lv_fire && !wr_lvsel) |=> $stable(lvsel))
    else $error("select changed");

  // Bad watchdog key sets its flag
  wdt_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    w_fire |=> cause[rsc_pkg::BIT_WDT])
    else $error("wdt flag not set");

  // Unused cause bits read zero
  cause_high_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    RD && ADDR == rsc_pkg::ADDR_CAUSE |=> RDATA[7:4] == 4'h0)
    else $error("cause high bits set");

  // Monitor enable drops at the pin in power-down
  pd_off_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    POWER_DOWN |=> !LV_ENABLE)
    else $error("lv enabled in power down");

  // Qualified low supply needs a low level before it
  lv_short_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    lv_fire |-> $past(!lv_ok && lv_en))
    else $error("unqualified lv");

  // Either key pattern stays quiet
  key_ok_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    guard_ok |-> !g_fire)
    else $error("guard fired on valid key");

  // Release only from the run state
  release_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(SYS_RST_N) |-> $past(state) == rsc_pkg::ST_RUN)
    else $error("early release");

  // Lowest threshold code drives bit zero of the one-hot
  thr_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (lvsel == rsc_pkg::LV_1V7) |=> (LV_THRESH == 5'h01))
    else $error("lowest threshold wrong");

  // Highest threshold code drives the top bit
  thr_high_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (lvsel == rsc_pkg::LV_3V8) |=> (LV_THRESH == 5'h10))
    else $error("highest threshold wrong");

  // Disable code turns the monitor off
  thr_off_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (lvsel == rsc_pkg::LV_OFF) |=> (LV_THRESH == 5'h00) && !LV_ENABLE)
    else $error("disable code ignored");

  // An unmasked event raises the interrupt; set beats clear
  irq_raise_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (|(set_ev & irq_msk) && !wr_imsk) |=> IRQ)
    else $error("interrupt not raised");

  // Clearing all status bits with no event drops the interrupt
  irq_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_ist && WDATA[3:0] == 4'hF && set_ev == 4'h0) |=> !IRQ)
    else $error("interrupt not cleared");

  // Writing zeros with no event clears every cause flag
  cause_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_cause && WDATA[3:0] == 4'h0 && set_ev == 4'h0) |=> (cause == 4'h0))
    else $error("cause not cleared");

  // No flag rises without its event
  cause_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (set_ev == 4'h0) |=> ((cause & ~$past(cause)) == 4'h0))
    else $error("flag set without event");

  // Read data is zero outside the read reply
  rd_idle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !RD |=> (RDATA == 8'h00))
    else $error("read data not idle");

  // Guard key reads back as stored
  guard_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (RD && ADDR == rsc_pkg::ADDR_GUARD) |=> (RDATA == $past(guard_key)))
    else $error("guard readback wrong");

  // Supply still low keeps the system in reset
  supply_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    supply_rst |=> !SYS_RST_N)
    else $error("released during low supply");

  // Release only after the full start-up count
  delay_count_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(SYS_RST_N) |-> ($past(dly_cnt, 2) == 32'(POR_DELAY - 1)))
    else $error("start-up delay short");

  // Bad watchdog key is restored
  wdt_restore_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    w_fire |=> (wdt_key == rsc_pkg::WDTKEY_POR))
    else $error("wdt key not restored");

  // Bad guard key is restored so it stops retriggering
  guard_restore_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    g_fire |=> (guard_key == rsc_pkg::GUARD_POR))
    else $error("guard key not restored");

  // Good supply or a disabled monitor restarts qualification
  lv_count_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (lv_ok || !lv_en) |=> (lv_cnt == 32'd0))
    else $error("lv count not restarted");

  // Register-guard trigger in run pulls the reset at once
  trig_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (trig_rst && state == rsc_pkg::ST_RUN) |=> (state == rsc_pkg::ST_HOLD) && !SYS_RST_N)
    else $error("trigger not combined");

  // Mask register takes its write
  mask_write_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_imsk |=> (irq_msk == $past(WDATA[3:0])))
    else $error("mask write lost");

  // Select register takes its write unless restored
  sel_write_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_lvsel && !l_fire) |=> (lvsel == $past(WDATA)))
    else $error("select write lost");

  // Cause flags read back as stored
  cause_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (RD && ADDR == rsc_pkg::ADDR_CAUSE) |=> (RDATA[3:0] == $past(cause)))
    else $error("cause readback wrong");

endmodule : rsc_top

// ==== tb/rsc_supply_model.sv ====
`timescale 1ns/1ps
module rsc_supply_model #(
  parameter int SLOW_HALF = 10
) (
  input  wire logic core_clk,
  output logic      slow_osc,
  output logic      below_n
);
  // Slow oscillator runs free; shortened period keeps the run brief
  initial
  begin
    slow_osc = 1'b0;
    below_n  = 1'b1;
    forever
    begin
      repeat (SLOW_HALF) @(posedge core_clk);
      slow_osc <= ~slow_osc;
    end
  end

  // Supply dip of n core cycles, seen as a level by the monitor
  task automatic dip(input int n);
    @(posedge core_clk);
    below_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    below_n <= 1'b1;
  endtask : dip
endmodule : rsc_supply_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam int POR_D = 20;
  localparam int LV_M  = 8;
  logic        core_clk;
  logic        rst_n;
  logic        slow_osc;
  logic        lv_below_n;
  logic        power_down;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [4:0]  lv_thresh;
  logic        lv_enable;
  logic        sys_rst_n;
  logic [15:0] pc_init;
  logic [7:0]  port_init;
  logic        irq;
  logic [7:0]  codes [5];
  int          bad_count;
  int          tests_run;

  rsc_supply_model u_sup (.core_clk(core_clk), .slow_osc(slow_osc), .below_n(lv_below_n));

  rsc_top #(.POR_DELAY(POR_D), .LV_MIN(LV_M)) DUT (
    .CORE_CLK(core_clk), .RST_N(rst_n), .SLOW_OSC(slow_osc), .LV_BELOW_N(lv_below_n),
    .POWER_DOWN(power_down), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .LV_THRESH(lv_thresh), .LV_ENABLE(lv_enable), .SYS_RST_N(sys_rst_n), .PC_INIT(pc_init),
    .PORT_INIT(port_init), .IRQ(irq));

  // Core clock, 10 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk

  // Bounded wait for the system reset to reach a level
  task automatic wait_sys(input logic lvl, input int lim);
    int n;
    n = 0;
    while (sys_rst_n !== lvl && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    #1;
    chk("sys_rst_n", {15'h0000, lvl}, {15'h0000, sys_rst_n});
  endtask : wait_sys

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far beyond the expected several hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0; power_down = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    bad_count = 0; tests_run = 0;
    codes = '{rsc_pkg::LV_1V7, rsc_pkg::LV_1V9, rsc_pkg::LV_2V55, rsc_pkg::LV_3V15,
              rsc_pkg::LV_3V8};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("pc_init", 16'h0000, pc_init);
    chk("port_init", 16'h00FF, {8'h00, port_init});
    rd_chk("guard", rsc_pkg::ADDR_GUARD, 8'h55);
    rd_chk("select", rsc_pkg::ADDR_LVSEL, 8'h66);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h00);
    rd_chk("unmapped", 4'hF, 8'h00);
    chk("early_rst", 16'h0000, {15'h0000, sys_rst_n});
    wait_sys(1'b1, POR_D + 10);
    wr_reg(rsc_pkg::ADDR_IRQ_MSK, 8'hFF);
    // Guard key: alternate pattern is quiet, anything else resets
    wr_reg(rsc_pkg::ADDR_GUARD, 8'hAA);
    repeat (80) @(posedge core_clk);
    chk("quiet_key", 16'h0001, {15'h0000, sys_rst_n});
    wr_reg(rsc_pkg::ADDR_GUARD, 8'h5A);
    wait_sys(1'b0, 80);
    chk("irq_set", 16'h0001, {15'h0000, irq});
    wait_sys(1'b1, POR_D + 20);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h08);
    rd_chk("guard", rsc_pkg::ADDR_GUARD, 8'h55);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'h00);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h00);
    wr_reg(rsc_pkg::ADDR_IRQ_ST, 8'hFF);
    #1;
    chk("irq_clr", 16'h0000, {15'h0000, irq});
    // Every threshold code, then the disable code
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(rsc_pkg::ADDR_LVSEL, codes[i]);
      repeat (3) @(posedge core_clk);
      chk("thresh", 16'h0001 << i, {11'h000, lv_thresh});
      chk("lv_en", 16'h0001, {15'h0000, lv_enable});
    end
    wr_reg(rsc_pkg::ADDR_LVSEL, rsc_pkg::LV_OFF);
    repeat (3) @(posedge core_clk);
    chk("lv_off", 16'h0000, {15'h0000, lv_enable});
    chk("thresh_off", 16'h0000, {11'h000, lv_thresh});
    // Undefined select code resets and restores the register
    wr_reg(rsc_pkg::ADDR_LVSEL, 8'h12);
    wait_sys(1'b0, 80);
    wait_sys(1'b1, POR_D + 20);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h02);
    rd_chk("select", rsc_pkg::ADDR_LVSEL, 8'h66);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'h00);
    // Short dip ignored, long dip resets and keeps the select code
    wr_reg(rsc_pkg::ADDR_LVSEL, rsc_pkg::LV_2V55);
    u_sup.dip(LV_M - 3);
    repeat (10) @(posedge core_clk);
    chk("short_dip", 16'h0001, {15'h0000, sys_rst_n});
    u_sup.dip(LV_M + 12);
    wait_sys(1'b0, 5);
    wait_sys(1'b1, POR_D + 20);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h04);
    rd_chk("select", rsc_pkg::ADDR_LVSEL, 8'h33);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'h00);
    // Power-down masks the supply monitor
    power_down <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("pd_en", 16'h0000, {15'h0000, lv_enable});
    u_sup.dip(LV_M + 12);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h00);
    power_down <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("pd_exit", 16'h0001, {15'h0000, lv_enable});
    // Invalid watchdog key in bits 7:3
    wr_reg(rsc_pkg::ADDR_WDTKEY, 8'h18);
    wait_sys(1'b0, 80);
    wait_sys(1'b1, POR_D + 20);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h01);
    wr_reg(rsc_pkg::ADDR_CAUSE, 8'h0E);
    rd_chk("cause", rsc_pkg::ADDR_CAUSE, 8'h00);
    end_of_test();
  end
endmodule : tb_top
